// >>> pser_map.svh
// register offsets, field positions and reset values of the event bank
// assumes inclusion by the bank module only
`ifndef PSER_MAP_SVH
`define PSER_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define PSER_OFS_IRQ_SUMMARY   8'h00
`define PSER_OFS_IRQ_MASK      8'h01
`define PSER_OFS_PWR_EV        8'h02
`define PSER_OFS_PWR_EV_RDCLR  8'h03
`define PSER_OFS_DET_EV        8'h04
`define PSER_OFS_DET_EV_RDCLR  8'h05
`define PSER_OFS_FLT_EV        8'h06
`define PSER_OFS_FLT_EV_RDCLR  8'h07
`define PSER_OFS_STRT_EV       8'h08
`define PSER_OFS_STRT_EV_RDCLR 8'h09
`define PSER_OFS_SUP_EV        8'h0A
`define PSER_OFS_SUP_EV_RDCLR  8'h0B
`define PSER_OFS_PORT_STATE    8'h0C
`define PSER_OFS_CONFIG        8'h17
`define PSER_OFS_GLOBAL_CTRL   8'h1A

// ****************************************
// field positions
// ****************************************
`define PSER_CFG_IRQ_EN_BIT    7
`define PSER_CFG_CAT_LIM_BIT   2
`define PSER_GLB_CLEAR_BIT     7
`define PSER_SUM_SUPPLY_BIT    7
`define PSER_SUM_STARTUP_BIT   6
`define PSER_SUM_OVERCUR_BIT   5
`define PSER_SUM_CATDONE_BIT   4
`define PSER_SUM_DISCDONE_BIT  3
`define PSER_SUM_REMOVED_BIT   2
`define PSER_SUM_PWRGOOD_BIT   1
`define PSER_SUM_PEN_BIT       0

// ****************************************
// reset values
// ****************************************
`define PSER_EVENT_RESET       8'h00
`define PSER_MASK_RESET        8'h00
`define PSER_CONFIG_RESET      8'h00
`define PSER_UNMAPPED_READ     8'h00

`endif

// >>> pser_pkg.sv
// types shared by the event and status register bank
// assumes nothing beyond a SystemVerilog compiler
package pser_pkg;

	// ****************************************
	// event register groups
	// ****************************************
	typedef enum logic [2:0] {
		PSER_GRP_PWR  = 3'b000,
		PSER_GRP_DET  = 3'b001,
		PSER_GRP_FLT  = 3'b010,
		PSER_GRP_STRT = 3'b011,
		PSER_GRP_SUP  = 3'b100,
		PSER_GRP_NONE = 3'b111
	} pser_group_type;

	typedef logic [3:0] pser_port_vec_type;
	typedef logic [7:0] pser_byte_type;

endpackage

// >>> pser_event_bank.sv
// event, status and summary registers of a quad-port power controller
// assumes a serial slave front end presenting byte reads and writes
`include "pser_map.svh"

module pser_event_bank (
	input  wire logic                       clk_i,
	input  wire logic                       rst_n_i,
	// byte access from the serial slave
	input  wire logic [7:0]                 reg_addr_i,
	input  wire logic                       reg_rd_i,
	input  wire logic                       reg_wr_i,
	input  wire logic [7:0]                 reg_wdata_i,
	output logic [7:0]                      reg_rdata_o,
	output logic                            reg_rvalid_o,
	// per-port status from the power state machines
	input  wire pser_pkg::pser_port_vec_type port_power_good_i,
	input  wire pser_pkg::pser_port_vec_type port_power_enabled_i,
	input  wire pser_pkg::pser_port_vec_type categorization_done_i,
	input  wire pser_pkg::pser_port_vec_type discovery_done_i,
	input  wire pser_pkg::pser_port_vec_type load_removed_i,
	input  wire pser_pkg::pser_port_vec_type overcurrent_shutdown_i,
	input  wire pser_pkg::pser_port_vec_type startup_period_end_i,
	input  wire pser_pkg::pser_port_vec_type port_in_current_limit_i,
	input  wire pser_pkg::pser_port_vec_type port_over_category_limit_i,
	input  wire logic [2:0]                 port_category_i,
	input  wire logic [2:0]                 port_discovery_state_i,
	// analog monitor comparators
	input  wire logic                       overtemperature_i,
	input  wire logic                       pos_supply_over_i,
	input  wire logic                       pos_supply_under_i,
	input  wire logic                       pos_supply_lockout_i,
	input  wire logic                       neg_supply_over_i,
	input  wire logic                       neg_supply_under_i,
	input  wire logic                       neg_supply_lockout_i,
	input  wire logic                       oscillator_low_i,
	// outputs to ports and host
	output pser_pkg::pser_port_vec_type      startup_shutdown_o,
	output pser_pkg::pser_port_vec_type      category_limit_active_o,
	output logic                            irq_n_o
);
	import pser_pkg::*;

	// ****************************************
	// state
	// ****************************************
	pser_byte_type     pwr_ev_r;
	pser_byte_type     det_ev_r;
	pser_byte_type     flt_ev_r;
	pser_byte_type     strt_ev_r;
	pser_byte_type     sup_ev_r;
	pser_byte_type     mask_r;
	pser_byte_type     config_r;
	pser_port_vec_type power_good_prev_r;
	pser_port_vec_type pen_prev_r;
	pser_byte_type     summary_nxt;
	pser_byte_type     pwr_set;
	pser_byte_type     det_set;
	pser_byte_type     flt_set;
	pser_byte_type     strt_set;
	pser_byte_type     sup_set;
	pser_port_vec_type start_fail;
	pser_group_type    rdclr_grp;
	logic              global_clear;

	// map a clear-on-read address to its group
	function automatic pser_group_type rdclr_group(input logic [7:0] a);
		case (a)
			`PSER_OFS_PWR_EV_RDCLR:  rdclr_group = PSER_GRP_PWR;
			`PSER_OFS_DET_EV_RDCLR:  rdclr_group = PSER_GRP_DET;
			`PSER_OFS_FLT_EV_RDCLR:  rdclr_group = PSER_GRP_FLT;
			`PSER_OFS_STRT_EV_RDCLR: rdclr_group = PSER_GRP_STRT;
			`PSER_OFS_SUP_EV_RDCLR:  rdclr_group = PSER_GRP_SUP;
			default:                 rdclr_group = PSER_GRP_NONE;
		endcase
	endfunction

	// next event register value: set wins over clear
	function automatic pser_byte_type ev_next(input pser_byte_type cur, input pser_byte_type set,
	                                          input logic clr);
		ev_next = (clr ? 8'h00 : cur) | set;
	endfunction

	// ****************************************
	// event sources
	// ****************************************
	// failed startup: still limiting or no power-good at period end
	assign start_fail = startup_period_end_i &
	                    (port_in_current_limit_i | ~port_power_good_i);

	// set vectors per register
	always_comb begin
		pwr_set  = {power_good_prev_r ^ port_power_good_i,
		            pen_prev_r ^ port_power_enabled_i};
		det_set  = {categorization_done_i, discovery_done_i};
		flt_set  = {load_removed_i, overcurrent_shutdown_i};
		strt_set = {port_over_category_limit_i, start_fail};
		sup_set  = {overtemperature_i, pos_supply_over_i, pos_supply_under_i,
		            neg_supply_lockout_i, neg_supply_over_i, neg_supply_under_i,
		            oscillator_low_i, pos_supply_lockout_i};
	end

	// previous levels for edge detection
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			power_good_prev_r <= 4'h0;
			pen_prev_r        <= 4'h0;
		end else begin
			power_good_prev_r <= port_power_good_i;
			pen_prev_r        <= port_power_enabled_i;
		end
	end

	// ****************************************
	// clear sources
	// ****************************************
	assign rdclr_grp    = reg_rd_i ? rdclr_group(reg_addr_i) : PSER_GRP_NONE;
	assign global_clear = reg_wr_i && (reg_addr_i == `PSER_OFS_GLOBAL_CTRL) &&
	                      reg_wdata_i[`PSER_GLB_CLEAR_BIT];

	// event registers; read data is captured in the same edge, so the
	// byte returned is the value before the clear
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pwr_ev_r  <= `PSER_EVENT_RESET;
			det_ev_r  <= `PSER_EVENT_RESET;
			flt_ev_r  <= `PSER_EVENT_RESET;
			strt_ev_r <= `PSER_EVENT_RESET;
			sup_ev_r  <= `PSER_EVENT_RESET;
		end else begin
			pwr_ev_r  <= ev_next(pwr_ev_r, pwr_set, global_clear || rdclr_grp == PSER_GRP_PWR);
			det_ev_r  <= ev_next(det_ev_r, det_set, global_clear || rdclr_grp == PSER_GRP_DET);
			flt_ev_r  <= ev_next(flt_ev_r, flt_set, global_clear || rdclr_grp == PSER_GRP_FLT);
			strt_ev_r <= ev_next(strt_ev_r, strt_set, global_clear || rdclr_grp == PSER_GRP_STRT);
			sup_ev_r  <= ev_next(sup_ev_r, sup_set, global_clear || rdclr_grp == PSER_GRP_SUP);
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			mask_r   <= `PSER_MASK_RESET;
			config_r <= `PSER_CONFIG_RESET;
		end else if (reg_wr_i) begin
			if (reg_addr_i == `PSER_OFS_IRQ_MASK) begin
				mask_r <= reg_wdata_i;
			end
			if (reg_addr_i == `PSER_OFS_CONFIG) begin
				config_r <= reg_wdata_i;
			end
		end
	end

	// ****************************************
	// interrupt summary
	// ****************************************
	always_comb begin
		summary_nxt                         = 8'h00;
		summary_nxt[`PSER_SUM_SUPPLY_BIT]   = |sup_ev_r;
		summary_nxt[`PSER_SUM_STARTUP_BIT]  = |strt_ev_r;
		summary_nxt[`PSER_SUM_OVERCUR_BIT]  = |flt_ev_r[3:0];
		summary_nxt[`PSER_SUM_CATDONE_BIT]  = |det_ev_r[7:4];
		summary_nxt[`PSER_SUM_DISCDONE_BIT] = |det_ev_r[3:0];
		summary_nxt[`PSER_SUM_REMOVED_BIT]  = |flt_ev_r[7:4];
		summary_nxt[`PSER_SUM_PWRGOOD_BIT]  = |pwr_ev_r[7:4];
		summary_nxt[`PSER_SUM_PEN_BIT]      = |pwr_ev_r[3:0];
	end

	// low-active interrupt from masked summary
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_n_o <= 1'b1;
		end else begin
			irq_n_o <= ~(config_r[`PSER_CFG_IRQ_EN_BIT] && |(summary_nxt & mask_r));
		end
	end

	// ****************************************
	// port controls
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			startup_shutdown_o      <= 4'h0;
			category_limit_active_o <= 4'h0;
		end else begin
			startup_shutdown_o      <= start_fail;
			category_limit_active_o <= {4{config_r[`PSER_CFG_CAT_LIM_BIT]}};
		end
	end

	// ****************************************
	// read path
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o  <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				case (reg_addr_i)
					`PSER_OFS_IRQ_SUMMARY:  reg_rdata_o <= summary_nxt;
					`PSER_OFS_IRQ_MASK:     reg_rdata_o <= mask_r;
					`PSER_OFS_PWR_EV,
					`PSER_OFS_PWR_EV_RDCLR: reg_rdata_o <= pwr_ev_r;
					`PSER_OFS_DET_EV,
					`PSER_OFS_DET_EV_RDCLR: reg_rdata_o <= det_ev_r;
					`PSER_OFS_FLT_EV,
					`PSER_OFS_FLT_EV_RDCLR: reg_rdata_o <= flt_ev_r;
					`PSER_OFS_STRT_EV,
					`PSER_OFS_STRT_EV_RDCLR: reg_rdata_o <= strt_ev_r;
					`PSER_OFS_SUP_EV,
					`PSER_OFS_SUP_EV_RDCLR: reg_rdata_o <= sup_ev_r;
					`PSER_OFS_PORT_STATE:   reg_rdata_o <= {1'b0, port_category_i,
					                                       1'b0, port_discovery_state_i};
					`PSER_OFS_CONFIG:       reg_rdata_o <= config_r;
					default:                reg_rdata_o <= `PSER_UNMAPPED_READ;
				endcase
			end
		end
	end

endmodule

// >>> pser_event_bank_assertions.sv
// checker of read timing, startup shutdown and interrupt gating
// assumes a bind onto pser_event_bank, one clock domain
module pser_event_bank_assertions (
	input wire logic                        clk_i,
	input wire logic                        rst_n_i,
	input wire logic [7:0]                  reg_addr_i,
	input wire logic                        reg_rd_i,
	input wire logic                        reg_wr_i,
	input wire logic [7:0]                  reg_wdata_i,
	input wire logic [7:0]                  reg_rdata_o,
	input wire logic                        reg_rvalid_o,
	input wire pser_pkg::pser_port_vec_type port_power_good_i,
	input wire pser_pkg::pser_port_vec_type startup_period_end_i,
	input wire pser_pkg::pser_port_vec_type port_in_current_limit_i,
	input wire pser_pkg::pser_port_vec_type port_over_category_limit_i,
	input wire logic [2:0]                  port_category_i,
	input wire logic [2:0]                  port_discovery_state_i,
	input wire pser_pkg::pser_port_vec_type startup_shutdown_o,
	input wire logic                        irq_n_o
);
	import pser_pkg::*;
	logic              cfg_en_r;
	pser_port_vec_type fail_vec;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ****
	// helper logic
	// ****
	// copy of the interrupt enable bit
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			cfg_en_r <= 1'h0;
		else if (reg_wr_i && reg_addr_i == 8'h17)
			cfg_en_r <= reg_wdata_i[7];
	end
	// ports whose startup ends badly
	assign fail_vec = startup_period_end_i & (port_in_current_limit_i | ~port_power_good_i);
	// ****
	// properties
	// ****
	AST_RVALID_AFTER_READ: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered next cycle");
	AST_RVALID_ONLY_READ: assert property (!reg_rd_i |=> !reg_rvalid_o)
		else $error("read valid without a read");
	AST_RDATA_HOLDS: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read byte changed without a read");
	AST_UNMAPPED_ZERO: assert property (reg_rd_i && reg_addr_i == 8'h40 |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	AST_PORT_STATE: assert property (reg_rd_i && reg_addr_i == 8'h0C |=>
		reg_rdata_o == {1'h0, $past(port_category_i), 1'h0, $past(port_discovery_state_i)})
		else $error("port state byte wrong");
	AST_STARTUP_SHUT: assert property ($past(rst_n_i) |-> startup_shutdown_o == $past(fail_vec))
		else $error("startup shutdown mismatch");
	AST_IRQ_DISABLED: assert property (!cfg_en_r [*2] |=> irq_n_o)
		else $error("interrupt driven while disabled");
	AST_SUMMARY_SIX: assert property ((port_over_category_limit_i != 4'h0) ##[1:4]
		(reg_rd_i && reg_addr_i == 8'h00) |=> reg_rdata_o[6])
		else $error("summary bit 6 not forced");
endmodule

bind pser_event_bank pser_event_bank_assertions i_pser_event_bank_assertions (.clk_i, .rst_n_i, .reg_addr_i,
	.reg_rd_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .port_power_good_i, .startup_period_end_i,
	.port_in_current_limit_i, .port_over_category_limit_i, .port_category_i, .port_discovery_state_i,
	.startup_shutdown_o, .irq_n_o);

// >>> pser_host_model.sv
// host side model issuing byte reads and writes
// assumes the bank answers a read one cycle after its strobe
module pser_host_model (
	input  wire logic       clk_i,
	output logic [7:0]      reg_addr_o,
	output logic            reg_rd_o,
	output logic            reg_wr_o,
	output logic [7:0]      reg_wdata_o,
	input  wire logic [7:0] reg_rdata_i,
	input  wire logic       reg_rvalid_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus at time zero
	initial begin
		reg_addr_o  = 8'h00;
		reg_rd_o    = 1'h0;
		reg_wr_o    = 1'h0;
		reg_wdata_o = 8'h00;
	end
	// one write strobe, then idle lines show inverted values
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_o  <= a;
		reg_wdata_o <= d;
		reg_wr_o    <= 1'h1;
		@(posedge clk_i);
		reg_wr_o    <= 1'h0;
		reg_addr_o  <= ~a;
		reg_wdata_o <= ~d;
	endtask
	// one read strobe, answer taken one cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(posedge clk_i);
		reg_addr_o <= a;
		reg_rd_o   <= 1'h1;
		@(posedge clk_i);
		reg_rd_o   <= 1'h0;
		reg_addr_o <= ~a;
		#1;
		ok = reg_rvalid_i;
		d  = reg_rdata_i;
	endtask
endmodule

// >>> tb_top.sv
// self-checking bench for the event register bank
// assumes pser_pkg, the bank, its checker and the host model
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pser_pkg::*;
	logic              clk_i, rst_n_i, rd, wr, rvalid, irq_n;
	logic [7:0]        addr, wdata, rdata;
	logic [31:0]       ev;
	logic [2:0]        cat3, dst;
	pser_port_vec_type pg, pen, ilim, shut, catlim;
	int                err_count, comparisons;
	// ****
	// design and host
	// ****
	pser_event_bank i_pser_event_bank (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_rd_i(rd),
		.reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .port_power_good_i(pg),
		.port_power_enabled_i(pen), .categorization_done_i(ev[3:0]), .discovery_done_i(ev[7:4]),
		.load_removed_i(ev[11:8]), .overcurrent_shutdown_i(ev[15:12]), .startup_period_end_i(ev[31:28]),
		.port_in_current_limit_i(ilim), .port_over_category_limit_i(ev[19:16]), .port_category_i(cat3),
		.port_discovery_state_i(dst), .overtemperature_i(ev[27]), .pos_supply_over_i(ev[26]),
		.pos_supply_under_i(ev[25]), .pos_supply_lockout_i(ev[20]), .neg_supply_over_i(ev[23]),
		.neg_supply_under_i(ev[22]), .neg_supply_lockout_i(ev[24]), .oscillator_low_i(ev[21]),
		.startup_shutdown_o(shut), .category_limit_active_o(catlim), .irq_n_o(irq_n));
	pser_host_model i_pser_host_model (.clk_i(clk_i), .reg_addr_o(addr), .reg_rd_o(rd), .reg_wr_o(wr),
		.reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
	// ****
	// shared tasks
	// ****
	task automatic stop_test;
		if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// read with answer check, a missing answer ends the run
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       ok;
		i_pser_host_model.rd(a, d, ok);
		if (ok !== 1'h1) begin
			err_count++;
			$display("Error %0t: no read answer at %h", $time, a);
			stop_test();
		end
		chk(d, exp);
	endtask
	// one-cycle strobe on the packed event inputs
	task automatic strobe_ev(input logic [31:0] v);
		@(posedge clk_i);
		ev <= v;
		@(posedge clk_i);
		ev <= 32'h0;
	endtask
	// ****
	// scenarios
	// ****
	task automatic sc_reset;
		for (int a = 0; a <= 12; a++) rdc(8'(a), 8'h00);
		rdc(8'h40, 8'h00);
	endtask
	task automatic sc_power;
		@(posedge clk_i);
		pg  <= 4'h2;
		pen <= 4'h9;
		rdc(8'h03, 8'h29);
		rdc(8'h02, 8'h00);
		@(posedge clk_i);
		pg <= 4'h0;
		rdc(8'h02, 8'h20);
	endtask
	task automatic sc_detect_fault;
		@(posedge clk_i);
		cat3 <= 3'h5;
		dst  <= 3'h6;
		strobe_ev(32'h0000_2418);
		rdc(8'h05, 8'h81);
		rdc(8'h04, 8'h00);
		fork
			rdc(8'h07, 8'h42);
			strobe_ev(32'h0000_1000);
		join
		rdc(8'h06, 8'h01);
		rdc(8'h0C, 8'h56);
		fork
			i_pser_host_model.wr(8'h1A, 8'h80);
			strobe_ev(32'h0000_0010);
		join
		rdc(8'h06, 8'h00);
		rdc(8'h05, 8'h01);
	endtask
	task automatic sc_startup;
		@(posedge clk_i);
		ilim <= 4'h8;
		pg   <= 4'h2;
		strobe_ev(32'hA005_0000);
		#1;
		chk({4'h0, shut}, 8'h08);
		rdc(8'h00, 8'h42);
		i_pser_host_model.wr(8'h01, 8'h40);
		i_pser_host_model.wr(8'h17, 8'h84);
		repeat (2) @(posedge clk_i);
		#1;
		chk({7'h00, irq_n}, 8'h00);
		chk({4'h0, catlim}, 8'h0F);
		rdc(8'h08, 8'h58);
		rdc(8'h09, 8'h58);
		rdc(8'h08, 8'h00);
		repeat (2) @(posedge clk_i);
		#1;
		chk({7'h00, irq_n}, 8'h01);
	endtask
	task automatic sc_supply;
		for (int i = 0; i < 8; i++) begin
			strobe_ev({4'h0, 8'h01 << i, 20'h00000});
			rdc(8'h0B, 8'h01 << i);
		end
	endtask
	// ****
	// clock and main sequence
	// ****
	initial begin
		clk_i = 1'h0;
		forever #20 clk_i = ~clk_i;
	end
	initial begin
		rst_n_i = 1'h0;
		ev = 32'h0;
		pg = 4'h0;
		pen = 4'h0;
		ilim = 4'h0;
		cat3 = 3'h0;
		dst = 3'h0;
		err_count = 0;
		comparisons = 0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'h1;
		sc_reset();
		sc_power();
		sc_detect_fault();
		sc_startup();
		sc_supply();
		stop_test();
	end
endmodule
